// file: hdl/buck_phase_pkg.sv
// constants shared by the buck phase grouping and termination tracking logic
package buck_phase_pkg;
  localparam int VOLT_W = 8;
  localparam int PHASE_W = 3;
  localparam int CFG_W = 2;
  localparam int NUM_BUCKS = 6;
  // phase shift codes: 000..110 are 45..315 degrees, 111 is zero shift
  localparam logic [2:0] PHASE_ZERO_DEG = 3'h7;
  localparam logic [2:0] PHASE_FIRST_STEP = 3'h0;
  // first group field
  localparam logic [1:0] CFG1_SINGLE = 2'h0;
  localparam logic [1:0] CFG1_DUAL = 2'h1;
  localparam logic [1:0] CFG1_QUAD = 2'h2;
  localparam logic [1:0] CFG1_TRIPLE = 2'h3;
  // second and third group fields; codes 10 and 11 are reserved
  localparam logic [1:0] CFG_PAIR_SINGLE = 2'h0;
  localparam logic [1:0] CFG_PAIR_DUAL = 2'h1;
  // bucks by index
  localparam int BUCK_ONE = 0;
  localparam int BUCK_TWO = 1;
  localparam int BUCK_THREE = 2;
  localparam int BUCK_FOUR = 3;
  localparam int BUCK_FIVE = 4;
  localparam int BUCK_SIX = 5;
  // ramp of buck six: one voltage code per step
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_STEP_NS = 2000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SIX_OFF,
    SIX_RAMP,
    SIX_TRACK,
    SIX_DIRECT
  } six_state_t;
endpackage : buck_phase_pkg

// file: hdl/rail_governor.sv
// per-regulator selection of governing settings and own phase register
`timescale 1ns/1ps
module rail_governor #(
  parameter int VW = buck_phase_pkg::VOLT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic follow,
  input wire logic [VW-1:0] own_voltage,
  input wire logic own_enable,
  input wire logic [VW-1:0] lead_voltage,
  input wire logic lead_enable,
  input wire logic phase_write,
  input wire logic [buck_phase_pkg::PHASE_W-1:0] phase_wdata,
  output logic [VW-1:0] voltage_q,
  output logic enable_q,
  output logic [buck_phase_pkg::PHASE_W-1:0] phase_q
);
  wire logic [VW-1:0] voltage_d = follow ? lead_voltage : own_voltage;
  wire logic enable_d = follow ? lead_enable : own_enable;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      voltage_q <= '0;
      enable_q <= 1'b0;
    end else begin
      voltage_q <= voltage_d;
      enable_q <= enable_d;
    end
  end

  // phase stays per regulator whatever the grouping
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= buck_phase_pkg::PHASE_ZERO_DEG;
    end else if (phase_write) begin
      phase_q <= phase_wdata;
    end
  end
endmodule : rail_governor

// file: hdl/buck_phase_vtt_control.sv
// phase grouping decode and termination tracking control for six bucks
// Operation
// - termination enable set: buck six reference becomes half buck five feedback
// - voltage scaling requests for buck six are ignored while tracking
// - six enabled with five in same slot tracks half of five immediately
// - six enabled after five ramps to its default code, then tracks
// - five disabled: six keeps tracking, both discharged by pull-downs
// - five re-enabled ramps up while six stays at half of it
// - only six disabled: pull-down select 0 high impedance, 1 discharge
// - six re-enabled ramps to run or standby code, then tracks again
// - quad grouping: bucks one to four governed by buck one
// - triple grouping: one to three governed by one, four independent
// - dual grouping of one and two governed by buck one
// - each member keeps its own phase shift field
// - first field: 00 single, 01 dual, 10 quad, 11 triple
// - three and four dual grouping governed by buck four
// - second field: 00 single, 01 dual, 10 and 11 reserved
// - quad or triple first grouping overrides the second field
// - five and six dual grouping governed by buck five
// - third field: 00 single, 01 dual, 10 and 11 reserved
// - every phase field resets to code 111, zero degrees
`timescale 1ns/1ps
module buck_phase_vtt_control #(
  parameter int VW = buck_phase_pkg::VOLT_W,
  parameter int RAMP_CYCLES = buck_phase_pkg::RAMP_STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [1:0] first_group_phase_config,
  input wire logic [1:0] second_group_phase_config,
  input wire logic [1:0] third_group_phase_config,
  input wire logic termination_mode_enable,
  input wire logic termination_pulldown_select,
  input wire logic [VW-1:0] buck_six_default_voltage,
  input wire logic standby_state,
  input wire logic [4*VW-1:0] low_bucks_voltage,
  input wire logic [VW-1:0] buck_five_run_voltage,
  input wire logic [VW-1:0] buck_five_standby_voltage,
  input wire logic [VW-1:0] buck_six_run_voltage,
  input wire logic [VW-1:0] buck_six_standby_voltage,
  input wire logic [5:0] regulator_enable,
  input wire logic [5:0] regulator_phase_write,
  input wire logic [2:0] regulator_phase_shift,
  output logic [6*VW-1:0] rail_voltage,
  output logic [5:0] rail_enable,
  output logic [17:0] rail_phase,
  output logic [5:0] rail_follow_q,
  output logic six_ref_track_q,
  output logic six_switch_on_q,
  output logic five_pulldown_q,
  output logic six_pulldown_q,
  output logic six_hiz_q
);
  if (VW < 2) begin : g_bad_vw
    $error("voltage code width must be at least 2");
  end
  if (RAMP_CYCLES < 1 || RAMP_CYCLES > 4096) begin : g_bad_ramp
    $error("ramp step cycles out of range 1..4096");
  end

  localparam int RW = $clog2(RAMP_CYCLES + 1);
  localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP_CYCLES - 1);

  // grouping decode
  wire logic g1_quad = first_group_phase_config == buck_phase_pkg::CFG1_QUAD;
  wire logic g1_triple = first_group_phase_config == buck_phase_pkg::CFG1_TRIPLE;
  wire logic g1_dual = first_group_phase_config == buck_phase_pkg::CFG1_DUAL;
  wire logic g1_wide = g1_quad | g1_triple;
  // reserved codes fall through to single phase
  wire logic g2_dual = !g1_wide &&
    second_group_phase_config == buck_phase_pkg::CFG_PAIR_DUAL;
  wire logic g3_dual =
    third_group_phase_config == buck_phase_pkg::CFG_PAIR_DUAL;

  wire logic [5:0] follow;
  assign follow[buck_phase_pkg::BUCK_ONE] = 1'b0;
  assign follow[buck_phase_pkg::BUCK_TWO] = g1_dual | g1_wide;
  assign follow[buck_phase_pkg::BUCK_THREE] = g1_wide | g2_dual;
  assign follow[buck_phase_pkg::BUCK_FOUR] = g1_quad;
  assign follow[buck_phase_pkg::BUCK_FIVE] = 1'b0;
  assign follow[buck_phase_pkg::BUCK_SIX] = g3_dual;

  // termination tracking only makes sense with five and six as separate rails
  wire logic vtt_on = termination_mode_enable && !g3_dual;
  wire logic five_req = regulator_enable[buck_phase_pkg::BUCK_FIVE];
  wire logic six_req = regulator_enable[buck_phase_pkg::BUCK_SIX];
  wire logic [VW-1:0] five_setting = standby_state ? buck_five_standby_voltage
                                                   : buck_five_run_voltage;
  wire logic [VW-1:0] six_setting = standby_state ? buck_six_standby_voltage
                                                  : buck_six_run_voltage;

  buck_phase_pkg::six_state_t state_q, state_d;
  logic five_on_q;
  logic started_q;
  logic [VW-1:0] six_dac_q, six_dac_d;
  logic [VW-1:0] target_q, target_d;
  logic [RW-1:0] ramp_cnt_q;

  wire logic five_rise = five_req && !five_on_q;
  wire logic ramp_tick = ramp_cnt_q == RAMP_LAST;
  wire logic ramp_done = six_dac_q == target_q;
  // first start after five uses the default code, a re-enable uses run or standby
  wire logic [VW-1:0] start_target = started_q ? six_setting
                                               : buck_six_default_voltage;
  wire logic [VW-1:0] step_up = six_dac_q + VW'(1);
  wire logic [VW-1:0] step_down = six_dac_q - VW'(1);

  always_comb begin
    state_d = state_q;
    target_d = target_q;
    unique case (state_q)
      buck_phase_pkg::SIX_OFF: begin
        if (six_req && !vtt_on) begin
          state_d = buck_phase_pkg::SIX_DIRECT;
        end else if (six_req && five_on_q) begin
          state_d = buck_phase_pkg::SIX_RAMP;
          target_d = start_target;
        end else if (six_req) begin
          state_d = buck_phase_pkg::SIX_TRACK;
        end
      end
      buck_phase_pkg::SIX_RAMP: begin
        if (!six_req) begin
          state_d = buck_phase_pkg::SIX_OFF;
        end else if (!vtt_on) begin
          state_d = buck_phase_pkg::SIX_DIRECT;
        end else if (ramp_done) begin
          state_d = buck_phase_pkg::SIX_TRACK;
        end
      end
      buck_phase_pkg::SIX_TRACK: begin
        // five going off or on again leaves six tracking
        if (!six_req) begin
          state_d = buck_phase_pkg::SIX_OFF;
        end else if (!vtt_on) begin
          state_d = buck_phase_pkg::SIX_DIRECT;
        end
      end
      buck_phase_pkg::SIX_DIRECT: begin
        if (!six_req) begin
          state_d = buck_phase_pkg::SIX_OFF;
        end else if (vtt_on) begin
          state_d = buck_phase_pkg::SIX_TRACK;
        end
      end
    endcase
  end

  always_comb begin
    six_dac_d = six_dac_q;
    if (state_q == buck_phase_pkg::SIX_RAMP) begin
      if (ramp_tick && six_dac_q < target_q) begin
        six_dac_d = step_up;
      end else if (ramp_tick && six_dac_q > target_q) begin
        six_dac_d = step_down;
      end
    end else if (state_q == buck_phase_pkg::SIX_OFF && vtt_on
                 && state_d == buck_phase_pkg::SIX_RAMP) begin
      six_dac_d = '0;
    end else if (!vtt_on) begin
      six_dac_d = six_setting; // in tracking the dac is frozen
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= buck_phase_pkg::SIX_OFF;
      target_q <= '0;
      six_dac_q <= '0;
      five_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      six_dac_q <= six_dac_d;
      five_on_q <= five_req;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      started_q <= 1'b0;
    end else if (state_q == buck_phase_pkg::SIX_TRACK) begin
      started_q <= 1'b1;
    end
  end

  // every ramp climbs from code zero, so a late restart costs the full climb
  // slow ramp enable; restarts with each new ramp
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ramp_cnt_q <= '0;
    end else if (state_q != buck_phase_pkg::SIX_RAMP || ramp_tick) begin
      ramp_cnt_q <= '0;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + RW'(1);
    end
  end

  // pin-level controls of the termination pair
  wire logic six_tracking = state_d == buck_phase_pkg::SIX_TRACK;
  wire logic six_running = state_d != buck_phase_pkg::SIX_OFF;
  wire logic pair_discharge = vtt_on && !five_req;
  // six waiting for its later slot also counts as disabled alone here
  wire logic six_alone_off = vtt_on && five_req && !six_req;
  wire logic six_pd_d = pair_discharge || (six_alone_off && termination_pulldown_select);
  wire logic six_hiz_d = six_alone_off && !termination_pulldown_select;
  wire logic six_sw_d = six_running && !pair_discharge;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      six_ref_track_q <= 1'b0;
      six_switch_on_q <= 1'b0;
      five_pulldown_q <= 1'b0;
      six_pulldown_q <= 1'b0;
      six_hiz_q <= 1'b0;
      rail_follow_q <= '0;
    end else begin
      six_ref_track_q <= six_tracking;
      six_switch_on_q <= six_sw_d;
      five_pulldown_q <= pair_discharge;
      six_pulldown_q <= six_pd_d;
      six_hiz_q <= six_hiz_d;
      rail_follow_q <= follow;
    end
  end

  // per-regulator settings and their governing leaders
  wire logic [6*VW-1:0] own_v = {six_dac_q, five_setting, low_bucks_voltage};
  wire logic [5:0] own_en = {six_sw_d, five_req, regulator_enable[3:0]};
  wire logic [6*VW-1:0] lead_v;
  wire logic [5:0] lead_en;
  wire logic [VW-1:0] v_one = low_bucks_voltage[buck_phase_pkg::BUCK_ONE*VW +: VW];
  wire logic [VW-1:0] v_four = low_bucks_voltage[buck_phase_pkg::BUCK_FOUR*VW +: VW];
  wire logic en_one = regulator_enable[buck_phase_pkg::BUCK_ONE];
  wire logic en_four = regulator_enable[buck_phase_pkg::BUCK_FOUR];
  assign lead_v = {five_setting, five_setting, v_one,
                   g1_wide ? v_one : v_four, v_one, v_one};
  assign lead_en = {five_req, five_req, en_one, g1_wide ? en_one : en_four, en_one, en_one};

  for (genvar i = 0; i < buck_phase_pkg::NUM_BUCKS; i++) begin : g_rail
    rail_governor #(.VW(VW)) u_gov (
      .mclk(mclk),
      .resetn(resetn),
      .follow(follow[i]),
      .own_voltage(own_v[i*VW +: VW]),
      .own_enable(own_en[i]),
      .lead_voltage(lead_v[i*VW +: VW]),
      .lead_enable(lead_en[i]),
      .phase_write(regulator_phase_write[i]),
      .phase_wdata(regulator_phase_shift),
      .voltage_q(rail_voltage[i*VW +: VW]),
      .enable_q(rail_enable[i]),
      .phase_q(rail_phase[i*buck_phase_pkg::PHASE_W +: buck_phase_pkg::PHASE_W])
    );
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_ref_on_track: assert property (
    state_d == buck_phase_pkg::SIX_TRACK && vtt_on |=> six_ref_track_q)
    else $error("tracking without the halved reference");
  a_dvs_held: assert property (
    state_q == buck_phase_pkg::SIX_TRACK && vtt_on && $changed(six_setting)
    |=> $stable(six_dac_q))
    else $error("buck six code moved while tracking");
  a_same_slot: assert property (
    state_q == buck_phase_pkg::SIX_OFF && vtt_on && six_req && five_rise
    |=> state_q == buck_phase_pkg::SIX_TRACK ##0 six_ref_track_q)
    else $error("same slot start did not track at once");
  a_later_ramp: assert property (
    state_q == buck_phase_pkg::SIX_OFF && vtt_on && six_req && five_on_q && !started_q
    |=> state_q == buck_phase_pkg::SIX_RAMP && target_q == $past(buck_six_default_voltage))
    else $error("later slot start did not ramp to default");
  a_pair_discharge: assert property (
    vtt_on && !five_req && six_req && state_q == buck_phase_pkg::SIX_TRACK
    |=> five_pulldown_q && six_pulldown_q && six_ref_track_q && !six_switch_on_q)
    else $error("pair not discharged together");
  a_five_back: assert property (
    vtt_on && five_rise && six_req && state_q == buck_phase_pkg::SIX_TRACK
    ##1 (vtt_on && six_req)
    |-> six_ref_track_q [*2])
    else $error("six left tracking when five came back");
  a_six_alone_off: assert property (
    vtt_on && five_req && !six_req
    |=> six_pulldown_q == $past(termination_pulldown_select) && six_hiz_q != six_pulldown_q)
    else $error("wrong disabled state of buck six");
  a_ramp_to_track: assert property (
    state_q == buck_phase_pkg::SIX_RAMP && ramp_done && six_req && vtt_on
    |=> state_q == buck_phase_pkg::SIX_TRACK ##0 six_ref_track_q)
    else $error("ramp end did not return to tracking");
  a_quad_lead: assert property (
    g1_quad ##1 g1_quad |=> rail_voltage[buck_phase_pkg::BUCK_FOUR*VW +: VW] == $past(v_one))
    else $error("quad member not governed by buck one");
  a_override: assert property (
    g1_triple |=> !rail_follow_q[buck_phase_pkg::BUCK_FOUR] && rail_follow_q[2])
    else $error("second field not overridden in triple phase");
  a_reserved: assert property (
    third_group_phase_config[1] |=> !rail_follow_q[buck_phase_pkg::BUCK_SIX])
    else $error("reserved code grouped bucks five and six");
  // grouping leaders and per-member phase registers
  a_dual_lead: assert property (
    g1_dual
    |=> rail_voltage[buck_phase_pkg::BUCK_TWO*VW +: VW] == $past(v_one))
    else $error("dual member not governed by buck one");
  a_triple_four: assert property (
    g1_triple
    |=> rail_voltage[buck_phase_pkg::BUCK_FOUR*VW +: VW] == $past(v_four))
    else $error("buck four not single in triple phase");
  a_pair_lead: assert property (
    g2_dual
    |=> rail_voltage[buck_phase_pkg::BUCK_THREE*VW +: VW] == $past(v_four))
    else $error("buck three not governed by buck four");
  a_five_lead: assert property (
    g3_dual
    |=> rail_voltage[buck_phase_pkg::BUCK_SIX*VW +: VW] == $past(five_setting))
    else $error("buck six not governed by buck five");
  a_first_decode: assert property (
    first_group_phase_config == buck_phase_pkg::CFG1_SINGLE
    |=> !rail_follow_q[buck_phase_pkg::BUCK_TWO] && !rail_follow_q[buck_phase_pkg::BUCK_FOUR])
    else $error("single code grouped bucks one and two");
  a_second_single: assert property (
    !g1_wide && second_group_phase_config == buck_phase_pkg::CFG_PAIR_SINGLE
    |=> !rail_follow_q[buck_phase_pkg::BUCK_THREE])
    else $error("second field single code grouped bucks three and four");
  a_phase_own: assert property (
    regulator_phase_write[buck_phase_pkg::BUCK_TWO]
    |=> rail_phase[buck_phase_pkg::BUCK_TWO*buck_phase_pkg::PHASE_W +: buck_phase_pkg::PHASE_W]
        == $past(regulator_phase_shift))
    else $error("phase write did not land in its own regulator");

  c_same_slot: cover property (
    state_q == buck_phase_pkg::SIX_OFF && vtt_on && six_req && five_rise);
  c_ramp_track: cover property (
    state_q == buck_phase_pkg::SIX_RAMP ##1 state_q == buck_phase_pkg::SIX_TRACK);
  c_reenable: cover property (started_q && state_q == buck_phase_pkg::SIX_RAMP);
  c_pair_off: cover property (five_pulldown_q && six_pulldown_q);
  c_dual_pairs: cover property (
    g1_dual && g2_dual && g3_dual);
endmodule : buck_phase_vtt_control

// file: testbench/host_settings_model.sv
// host model that programs the buck five and buck six voltage codes
`timescale 1ns/1ps
module host_settings_model (
  input wire logic [7:0] five_run_set,
  input wire logic [7:0] five_stby_set,
  output logic [7:0] five_run,
  output logic [7:0] five_stby,
  output logic [7:0] six_run,
  output logic [7:0] six_stby
);
  // code 8'h40 is 800 mV; lower requests are raised so buck six can still regulate
  localparam logic [7:0] FIVE_MIN = 8'h40;
  assign five_run = (five_run_set < FIVE_MIN) ? FIVE_MIN : five_run_set;
  assign five_stby = (five_stby_set < FIVE_MIN) ? FIVE_MIN : five_stby_set;
  // half the voltage is half the code span above 8'h40 (800 mV), rounded down to a code
  assign six_run = (five_run - FIVE_MIN) >> 1;
  assign six_stby = (five_stby - FIVE_MIN) >> 1;
endmodule : host_settings_model

// file: testbench/buck_phase_vtt_control_tb.sv
// self-checking bench for phase grouping and termination tracking
`timescale 1ns/1ps
module buck_phase_vtt_control_tb;
  localparam int VW = buck_phase_pkg::VOLT_W;
  localparam int RC = 2;
  localparam logic [7:0] DEF = 8'h05;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] grp1 = 2'h0;
  logic [1:0] grp2 = 2'h0;
  logic [1:0] grp3 = 2'h0;
  logic vtt_en = 1'b0;
  logic pd_sel = 1'b0;
  logic standby = 1'b0;
  logic [4*VW-1:0] low_v = 32'h44332211;
  logic [5:0] en = 6'h39;
  logic [5:0] ph_wr = 6'h00;
  logic [2:0] ph_code = 3'h0;
  logic [7:0] five_run_set = 8'h60;
  logic [7:0] five_stby_set = 8'h50;
  logic [7:0] f_run;
  logic [7:0] f_stby;
  logic [7:0] s_run;
  logic [7:0] s_stby;
  logic [6*VW-1:0] rv;
  logic [5:0] re;
  logic [17:0] rp;
  logic [5:0] rf;
  logic trk;
  logic sw_on;
  logic pd5;
  logic pd6;
  logic hiz;
  int err_total = 0;
  int checks = 0;

  host_settings_model host (.five_run_set(five_run_set), .five_stby_set(five_stby_set),
    .five_run(f_run), .five_stby(f_stby), .six_run(s_run), .six_stby(s_stby));

  buck_phase_vtt_control #(.VW(VW), .RAMP_CYCLES(RC)) dut (.mclk(mclk), .resetn(resetn),
    .first_group_phase_config(grp1), .second_group_phase_config(grp2),
    .third_group_phase_config(grp3), .termination_mode_enable(vtt_en),
    .termination_pulldown_select(pd_sel), .buck_six_default_voltage(DEF),
    .standby_state(standby), .low_bucks_voltage(low_v),
    .buck_five_run_voltage(f_run), .buck_five_standby_voltage(f_stby),
    .buck_six_run_voltage(s_run), .buck_six_standby_voltage(s_stby),
    .regulator_enable(en), .regulator_phase_write(ph_wr), .regulator_phase_shift(ph_code),
    .rail_voltage(rv), .rail_enable(re), .rail_phase(rp), .rail_follow_q(rf),
    .six_ref_track_q(trk), .six_switch_on_q(sw_on), .five_pulldown_q(pd5),
    .six_pulldown_q(pd6), .six_hiz_q(hiz));

  initial begin
    forever #50 mclk = ~mclk;
  end

  task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task conclude;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // outputs are looked at 10 ns after an edge, once its updates have landed
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : wt

  task wait_track(output int n);
    n = 0;
    while (trk !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    #9;
  endtask : wait_track

  function automatic logic [7:0] vof(input int i);
    return rv[i*VW +: VW];
  endfunction : vof

  initial begin : main
    int n;
    int ld [6];
    logic [5:0] fol;
    logic [5:0] ren;
    wt(11);
    chk("reset phase", 18'h3FFFF, rp);
    chk("reset flags", 11'h000, {rf, trk, sw_on, pd5, pd6, hiz});
    @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      ph_wr <= 6'h01 << i;
      ph_code <= 3'(i);
    end
    @(posedge mclk);
    ph_wr <= 6'h00;
    wt(2);
    chk("phase", 18'h2C688, rp);
    for (int c1 = 0; c1 < 4; c1++) begin
      for (int c2 = 0; c2 < 4; c2++) begin
        @(posedge mclk);
        grp1 <= 2'(c1);
        grp2 <= 2'(c2);
        grp3 <= 2'(c2);
        wt(3);
        for (int i = 0; i < 6; i++) ld[i] = i;
        if (c1 == 1) ld[1] = 0;
        if (c1 >= 2) begin
          ld[1] = 0;
          ld[2] = 0;
          if (c1 == 2) ld[3] = 0;
        end
        if (c1 < 2 && c2 == 1) ld[2] = 3;
        if (c2 == 1) ld[5] = 4;
        for (int i = 0; i < 6; i++) begin
          fol[i] = (ld[i] != i);
          ren[i] = en[ld[i]];
        end
        chk("follow", fol, rf);
        chk("enable", ren, re);
        for (int i = 0; i < 4; i++) chk("voltage", low_v[ld[i]*VW +: VW], vof(i));
        chk("voltage five", f_run, vof(4));
        chk("voltage six", (ld[5] == 4) ? f_run : s_run, vof(5));
      end
    end
    chk("phase kept", 18'h2C688, rp);
    // second reset so the first start of buck six ramps to its default code
    @(posedge mclk);
    resetn <= 1'b0;
    grp1 <= 2'h0;
    grp2 <= 2'h0;
    grp3 <= 2'h0;
    wt(2);
    @(posedge mclk);
    resetn <= 1'b1;
    vtt_en <= 1'b1;
    en <= 6'h10;
    wt(3);
    @(posedge mclk);
    en <= 6'h30;
    wait_track(n);
    chk("ramp span", 1'b1, n >= DEF * RC && n <= DEF * RC + 4);
    chk("six default", DEF, vof(5));
    @(posedge mclk);
    five_run_set <= 8'h70;
    wt(3);
    chk("six scaling", DEF, vof(5));
    @(posedge mclk);
    five_run_set <= 8'h60;
    pd_sel <= 1'b1;
    en <= 6'h10;
    wt(1);
    chk("six off pull", 2'b10, {pd6, hiz});
    @(posedge mclk);
    en <= 6'h30;
    wait_track(n);
    wt(2);
    chk("six rerun", 8'h10, vof(5));
    @(posedge mclk);
    pd_sel <= 1'b0;
    en <= 6'h10;
    wt(1);
    chk("six off hiz", 2'b01, {pd6, hiz});
    @(posedge mclk);
    standby <= 1'b1;
    en <= 6'h30;
    wait_track(n);
    wt(2);
    chk("six restandby", 8'h08, vof(5));
    @(posedge mclk);
    standby <= 1'b0;
    en <= 6'h20;
    wt(1);
    chk("five off", 4'hD, {pd5, pd6, sw_on, trk});
    @(posedge mclk);
    en <= 6'h30;
    repeat (3) begin
      wt(1);
      chk("track kept", 1'b1, trk);
    end
    chk("five on", 8'h60, vof(4));
    @(posedge mclk);
    en <= 6'h00;
    wt(3);
    @(posedge mclk);
    en <= 6'h30;
    wt(1);
    chk("same slot", 2'b11, {trk, sw_on});
    conclude();
  end

  // the sequence needs well under a thousand cycles; ten thousand means a hang
  initial begin : watchdog
    #1000000;
    err_total++;
    conclude();
  end
endmodule : buck_phase_vtt_control_tb
